// *** ddrac_pkg.sv ***
package ddrac_pkg;

    // Geometry of the command side
    localparam int ADDR_W = 13;
    localparam int BANK_W = 3;
    localparam int COL_W  = 10;
    localparam int NBANK  = 8;
    localparam int TIME_W = 8;
    localparam int LAT_W  = 4;

    // Mode register field positions, and the auto-precharge address bit
    localparam int MR_BL_LSB  = 0;
    localparam int MR_BT_BIT  = 3;
    localparam int MR_CL_LSB  = 4;
    localparam int MR_PD_BIT  = 12;
    localparam int EMR_RTT_LO = 2;
    localparam int EMR_AL_LSB = 3;
    localparam int EMR_RTT_HI = 6;
    localparam int AUTO_PRE_BIT = 10;

    // Mode register select codes on the low bank bits
    localparam logic [1:0] BA_SEL_MR  = 2'h0;
    localparam logic [1:0] BA_SEL_EMR = 2'h1;

    // Burst length codes and last beat index
    localparam logic [2:0] BL_CODE4  = 3'h2;
    localparam logic [2:0] BL_CODE8  = 3'h3;
    localparam logic [2:0] LAST_BL4  = 3'h3;
    localparam logic [2:0] LAST_BL8  = 3'h7;

    // Reset values of the mode fields, and the additive latency cap
    localparam logic [2:0] BL_RST = BL_CODE4;
    localparam logic [2:0] CL_RST = 3'h3;
    localparam logic [2:0] AL_RST = 3'h0;
    localparam logic [2:0] AL_MAX = 3'h6;

    // Termination delays, in link clock cycles and in link half cycles
    localparam real TAOND_CK   = 2.0;
    localparam real TAOFD_CK   = 2.5;
    localparam int  TAOND_HALF = int'(TAOND_CK * 2.0);
    localparam int  TAOFD_HALF = int'(TAOFD_CK * 2.0);
    localparam int  ODT_HIST_W = (TAOFD_HALF + 1) / 2;

    // Decoded command
    typedef enum logic [2:0] {
        CMD_NOP   = 3'h0,
        CMD_ACT   = 3'h1,
        CMD_RD    = 3'h2,
        CMD_WR    = 3'h3,
        CMD_PRE   = 3'h4,
        CMD_REF   = 3'h5,
        CMD_MRS   = 3'h6,
        CMD_DESEL = 3'h7
    } ddrac_cmd_t;

    // Nominal termination, coded as {A6,A2}
    typedef enum logic [1:0] {
        RTT_OFF = 2'h0,
        RTT_75  = 2'h1,
        RTT_150 = 2'h2,
        RTT_50  = 2'h3
    } ddrac_rtt_t;

    // Burst engine states
    typedef enum logic {
        ENG_IDLE  = 1'b0,
        ENG_BURST = 1'b1
    } ddrac_eng_t;

    // Pins as seen at the device edge
    typedef struct packed {
        logic              ck;
        logic              cke;
        logic              odt;
        logic              csN;
        logic              rasN;
        logic              casN;
        logic              weN;
        logic [BANK_W-1:0] ba;
        logic [ADDR_W-1:0] addr;
    } ddrac_pins_t;

    // Posted column command
    typedef struct packed {
        logic              write;
        logic              autoPre;
        logic [BANK_W-1:0] bank;
        logic [COL_W-1:0]  col;
        logic [TIME_W-1:0] due;
    } ddrac_col_t;

    // One internal burst beat
    typedef struct packed {
        logic              write;
        logic              last;
        logic [BANK_W-1:0] bank;
        logic [ADDR_W-1:0] row;
        logic [COL_W-1:0]  col;
        logic [LAT_W-1:0]  dataDelay;
    } ddrac_beat_t;

endpackage

// *** ddrac_sync.sv ***
module ddrac_sync #(
    parameter int W = 1
) (
    input  wire logic         ref_clk,
    input  wire logic         rst,
    input  wire logic [W-1:0] async,
    output logic      [W-1:0] synced
);

    // First stage feeds only the second
    logic [W-1:0] meta;

    // Two flop synchroniser
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            meta   <= '0;
            synced <= '0;
        end else begin
            meta   <= async;
            synced <= meta;
        end
    end

endmodule

// *** ddrac_fifo.sv ***
module ddrac_fifo #(
    parameter int W     = 8,
    parameter int DEPTH = 4
) (
    input  wire logic         ref_clk,
    input  wire logic         rst,
    input  wire logic         inValid,
    output logic              inReady,
    input  wire logic [W-1:0] inData,
    output logic              outValid,
    input  wire logic         outReady,
    output logic      [W-1:0] outData
);

    localparam int PW = $clog2(DEPTH);

    logic [W-1:0]  mem [DEPTH];  // Storage words
    logic [PW-1:0] wrPtr;        // Next write slot
    logic [PW-1:0] rdPtr;        // Oldest word
    logic [PW:0]   count;        // Words held

    wire doWrite = inValid && inReady;
    wire doRead  = outValid && outReady;

    // Honest flags from the occupancy count
    assign inReady  = (count != (PW+1)'(DEPTH));
    assign outValid = (count != '0);
    assign outData  = mem[rdPtr];

    // Storage write, no reset needed on data
    always_ff @(posedge ref_clk) begin
        if (doWrite) begin
            mem[wrPtr] <= inData;
        end
    end

    // Pointers wrap at the depth
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            wrPtr <= '0;
            rdPtr <= '0;
            count <= '0;
        end else begin
            if (doWrite) begin
                wrPtr <= (wrPtr == PW'(DEPTH - 1)) ? '0 : wrPtr + 1'b1;
            end
            if (doRead) begin
                rdPtr <= (rdPtr == PW'(DEPTH - 1)) ? '0 : rdPtr + 1'b1;
            end
            count <= count + (PW+1)'(doWrite) - (PW+1)'(doRead);
        end
    end

endmodule

// *** ddrac_core.sv ***
module ddrac_core #(
    parameter int FIFO_DEPTH = 4
) (
    input  wire logic                          ref_clk,
    input  wire logic                          rst,
    input  wire logic                          ckPin,
    input  wire logic                          ckePin,
    input  wire logic                          odtPin,
    input  wire logic                          csNPin,
    input  wire logic                          rasNPin,
    input  wire logic                          casNPin,
    input  wire logic                          weNPin,
    input  wire logic [ddrac_pkg::BANK_W-1:0]  baPin,
    input  wire logic [ddrac_pkg::ADDR_W-1:0]  addrPin,
    input  wire logic                          beatReady,
    output logic                               beatValid,
    output ddrac_pkg::ddrac_beat_t             beat,
    output logic                               colReady,
    output logic                               termOn,
    output ddrac_pkg::ddrac_rtt_t              rttSel,
    output logic [ddrac_pkg::LAT_W-1:0]        readLatency,
    output logic [ddrac_pkg::LAT_W-1:0]        writeLatency,
    output logic [ddrac_pkg::NBANK-1:0]        bankOpen,
    output logic                               powerDown,
    output logic                               selfRefresh
);

    // Pin sampling
    ddrac_pkg::ddrac_pins_t pinsRaw;  // Pins as a bundle
    ddrac_pkg::ddrac_pins_t pins;     // Pins after two flops
    logic                   ckPrev;   // Link clock one cycle back

    assign pinsRaw = '{ck: ckPin, cke: ckePin, odt: odtPin, csN: csNPin,
                       rasN: rasNPin, casN: casNPin, weN: weNPin,
                       ba: baPin, addr: addrPin};

    // All pins cross together so command bits stay aligned with the clock
    ddrac_sync #(
        .W ($bits(ddrac_pkg::ddrac_pins_t))
    ) u_sync (
        .ref_clk (ref_clk),
        .rst     (rst),
        .async   (pinsRaw),
        .synced  (pins)
    );

    // Edge finder on the sampled link clock
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            ckPrev <= 1'b0;
        end else begin
            ckPrev <= pins.ck;
        end
    end

    wire ckRise = pins.ck && !ckPrev;  // Command sampling point
    wire ckFall = !pins.ck && ckPrev;  // Half cycle point
    wire ckEdge = ckRise || ckFall;    // Each data beat slot

    // Command decode
    ddrac_pkg::ddrac_cmd_t cmd;  // Command at this edge

    assign cmd = pins.csN ? ddrac_pkg::CMD_DESEL :
        ({pins.rasN, pins.casN, pins.weN} == 3'h3) ? ddrac_pkg::CMD_ACT :
        ({pins.rasN, pins.casN, pins.weN} == 3'h5) ? ddrac_pkg::CMD_RD  :
        ({pins.rasN, pins.casN, pins.weN} == 3'h4) ? ddrac_pkg::CMD_WR  :
        ({pins.rasN, pins.casN, pins.weN} == 3'h2) ? ddrac_pkg::CMD_PRE :
        ({pins.rasN, pins.casN, pins.weN} == 3'h1) ? ddrac_pkg::CMD_REF :
        ({pins.rasN, pins.casN, pins.weN} == 3'h0) ? ddrac_pkg::CMD_MRS :
        ddrac_pkg::CMD_NOP;

    // Commands count only while the clock enable is high, except self refresh entry, which needs it low
    wire cmdEdge  = ckRise && pins.cke;
    wire doAct    = cmdEdge && (cmd == ddrac_pkg::CMD_ACT);
    wire doPre    = cmdEdge && (cmd == ddrac_pkg::CMD_PRE);
    wire doCol    = cmdEdge && (cmd == ddrac_pkg::CMD_RD || cmd == ddrac_pkg::CMD_WR);
    wire doMrs    = cmdEdge && (cmd == ddrac_pkg::CMD_MRS);
    wire loadMr   = doMrs && (pins.ba[1:0] == ddrac_pkg::BA_SEL_MR);
    wire loadEmr  = doMrs && (pins.ba[1:0] == ddrac_pkg::BA_SEL_EMR);
    wire preAll   = pins.addr[ddrac_pkg::AUTO_PRE_BIT];
    wire srEnter  = ckRise && !pins.cke && (cmd == ddrac_pkg::CMD_REF);

    // Mode fields
    logic [2:0] blCode;     // Burst length code
    logic       interleave; // Burst order
    logic [2:0] casLat;     // CAS latency
    logic       lowPowerPd; // Power-down flavour
    logic [2:0] addLat;     // Additive latency
    logic [1:0] rttCode;    // Termination code

    // Mode register writes; other bits of these registers are not kept
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            blCode     <= ddrac_pkg::BL_RST;
            interleave <= 1'b0;
            casLat     <= ddrac_pkg::CL_RST;
            lowPowerPd <= 1'b0;
            addLat     <= ddrac_pkg::AL_RST;
            rttCode    <= ddrac_pkg::RTT_OFF;
        end else if (loadMr) begin
            blCode     <= pins.addr[ddrac_pkg::MR_BL_LSB +: 3];
            interleave <= pins.addr[ddrac_pkg::MR_BT_BIT];
            casLat     <= pins.addr[ddrac_pkg::MR_CL_LSB +: 3];
            lowPowerPd <= pins.addr[ddrac_pkg::MR_PD_BIT];
        end else if (loadEmr) begin
            addLat     <= pins.addr[ddrac_pkg::EMR_AL_LSB +: 3];
            rttCode    <= {pins.addr[ddrac_pkg::EMR_RTT_HI],
                           pins.addr[ddrac_pkg::EMR_RTT_LO]};
        end
    end

    // Only length 8 is treated as long; any other code runs as 4
    wire bl8 = (blCode == ddrac_pkg::BL_CODE8);

    wire [2:0] alEff = (addLat > ddrac_pkg::AL_MAX) ? ddrac_pkg::AL_MAX : addLat;

    wire [ddrac_pkg::LAT_W-1:0] rlSum = ddrac_pkg::LAT_W'(alEff) +
                                        ddrac_pkg::LAT_W'(casLat);

    // Latencies registered for the outside
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            readLatency  <= '0;
            writeLatency <= '0;
        end else begin
            readLatency  <= rlSum;
            writeLatency <= rlSum - 1'b1;
        end
    end

    // Power states
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            selfRefresh <= 1'b0;
            powerDown   <= 1'b0;
        end else if (ckRise) begin
            // Self refresh lasts until the clock enable returns
            if (srEnter) begin
                selfRefresh <= 1'b1;
            end else if (pins.cke) begin
                selfRefresh <= 1'b0;
            end
            powerDown <= !pins.cke && !srEnter && !selfRefresh;
        end
    end

    // Termination control
    localparam int ODT_W   = ddrac_pkg::ODT_HIST_W;
    localparam int ON_TAP  = ddrac_pkg::TAOND_HALF / 2 - 1;
    localparam int OFF_TAP = ddrac_pkg::TAOFD_HALF / 2;

    logic [ODT_W-1:0] odtHist;  // Control samples at rising edges
    logic             next_termOn;

    // Control history shifts only on rising edges
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            odtHist <= '0;
        end else if (ckRise) begin
            odtHist <= {odtHist[ODT_W-2:0], pins.odt};
        end
    end

    wire termAllowed = !selfRefresh && (rttCode != ddrac_pkg::RTT_OFF);
    wire asyncOdt    = powerDown && lowPowerPd;

    // Next termination state
    always_comb begin
        next_termOn = termOn;
        if (!termAllowed) begin
            next_termOn = 1'b0;
        end else if (asyncOdt) begin
            // Low power flavour follows the control without fixed delay
            next_termOn = pins.odt;
        end else if (ckRise && odtHist[ON_TAP]) begin
            next_termOn = 1'b1;
        end else if (ckFall && !odtHist[OFF_TAP]) begin
            next_termOn = 1'b0;
        end
    end

    // Termination outputs
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            termOn <= 1'b0;
            rttSel <= ddrac_pkg::RTT_OFF;
        end else begin
            termOn <= next_termOn;
            rttSel <= ddrac_pkg::ddrac_rtt_t'(rttCode);
        end
    end

    // Bank rows
    logic [ddrac_pkg::ADDR_W-1:0] openRow [ddrac_pkg::NBANK];  // Row per bank
    logic [ddrac_pkg::TIME_W-1:0] ckCount;  // Rising edge count

    always_ff @(posedge ref_clk) begin
        if (doAct) begin
            openRow[pins.ba] <= pins.addr;
        end
    end

    // Time base for posted commands
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            ckCount <= '0;
        end else if (ckRise) begin
            ckCount <= ckCount + 1'b1;
        end
    end

    // Posted command queue
    ddrac_pkg::ddrac_col_t colIn;   // Command entering
    ddrac_pkg::ddrac_col_t colHead; // Oldest waiting
    logic                  headValid;
    logic                  popHead;

    assign colIn = '{write: (cmd == ddrac_pkg::CMD_WR),
                     autoPre: pins.addr[ddrac_pkg::AUTO_PRE_BIT],
                     bank: pins.ba,
                     col: pins.addr[ddrac_pkg::COL_W-1:0],
                     due: ckCount + ddrac_pkg::TIME_W'(alEff) + 1'b1};

    // Four deep queue covers the most posted commands legal spacing allows
    ddrac_fifo #(
        .W     ($bits(ddrac_pkg::ddrac_col_t)),
        .DEPTH (FIFO_DEPTH)
    ) u_fifo (
        .ref_clk  (ref_clk),
        .rst      (rst),
        .inValid  (doCol),
        .inReady  (colReady),
        .inData   (colIn),
        .outValid (headValid),
        .outReady (popHead),
        .outData  (colHead)
    );

    // Wrap safe comparison against the edge count
    wire [ddrac_pkg::TIME_W-1:0] sinceDue = ckCount - colHead.due;
    wire dueReached = !sinceDue[ddrac_pkg::TIME_W-1];

    // Burst engine
    ddrac_pkg::ddrac_eng_t engState;
    ddrac_pkg::ddrac_col_t cur;     // Burst in progress
    logic [2:0]            beatIdx; // Beat number
    logic                  curBl8;  // Length latched at start
    logic                  curIlv;  // Order latched at start
    logic [2:0]            curCl;   // CAS latency at start

    // Column of one beat in either order
    function automatic logic [2:0] burstCol(
        input logic [2:0] start,
        input logic [2:0] idx,
        input logic       ilv,
        input logic       long8
    );
        logic [2:0] step;
        step = long8 ? idx : {1'b0, idx[1:0]};
        if (ilv) begin
            burstCol = start ^ step;
        end else begin
            burstCol = {start[2] ^ step[2], start[1:0] + step[1:0]};
        end
    endfunction

    assign popHead = headValid && dueReached && (engState == ddrac_pkg::ENG_IDLE);

    wire [2:0] lastIdx  = curBl8 ? ddrac_pkg::LAST_BL8 : ddrac_pkg::LAST_BL4;
    wire       beatGo   = (engState == ddrac_pkg::ENG_BURST) && ckEdge && beatReady;
    wire       beatLast = (beatIdx == lastIdx);
    wire [2:0] colLow   = burstCol(cur.col[2:0], beatIdx, curIlv, curBl8);
    wire [ddrac_pkg::LAT_W-1:0] clLat = ddrac_pkg::LAT_W'(curCl);

    // Engine sequence; a stalled sink delays beats and fills the queue
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            engState <= ddrac_pkg::ENG_IDLE;
            cur      <= '0;
            beatIdx  <= '0;
            curBl8   <= 1'b0;
            curIlv   <= 1'b0;
            curCl    <= ddrac_pkg::CL_RST;
        end else begin
            case (engState)
                ddrac_pkg::ENG_IDLE: begin
                    if (popHead) begin
                        cur      <= colHead;
                        beatIdx  <= '0;
                        curBl8   <= bl8;
                        curIlv   <= interleave;
                        curCl    <= casLat;
                        engState <= ddrac_pkg::ENG_BURST;
                    end
                end
                ddrac_pkg::ENG_BURST: begin
                    if (beatGo) begin
                        beatIdx <= beatIdx + 1'b1;
                        if (beatLast) begin
                            engState <= ddrac_pkg::ENG_IDLE;
                        end
                    end
                end
                default: begin
                    engState <= ddrac_pkg::ENG_IDLE;
                end
            endcase
        end
    end

    // Beat output register
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            beatValid <= 1'b0;
            beat      <= '0;
        end else begin
            beatValid <= beatGo;
            if (beatGo) begin
                beat.write <= cur.write;
                beat.last  <= beatLast;
                beat.bank  <= cur.bank;
                beat.row   <= openRow[cur.bank];
                beat.col   <= {cur.col[ddrac_pkg::COL_W-1:3], colLow};
                beat.dataDelay <= cur.write ? clLat - 1'b1 : clLat;
            end
        end
    end

    wire apDone = beatGo && beatLast && cur.autoPre;

    // Bank open flags; a new activate wins over a closing event
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            bankOpen <= '0;
        end else begin
            for (int b = 0; b < ddrac_pkg::NBANK; b++) begin
                if (doAct && (pins.ba == ddrac_pkg::BANK_W'(b))) begin
                    bankOpen[b] <= 1'b1;
                end else if (doPre && (preAll || pins.ba == ddrac_pkg::BANK_W'(b))) begin
                    bankOpen[b] <= 1'b0;
                end else if (apDone && (cur.bank == ddrac_pkg::BANK_W'(b))) begin
                    bankOpen[b] <= 1'b0;
                end
            end
        end
    end

endmodule

// *** ddrac_ctl_model.sv ***
module ddrac_ctl_model (
    output ddrac_pkg::ddrac_pins_t pins
);
    timeunit 1ns;
    timeprecision 100ps;
    // CK and odt start low, command lines high, bank and address zero; cke starts high
    initial pins = {3'h2, 4'hF, 3'h0, 13'h0};
    // Free-running CK, never on a rising core edge
    always #80 pins.ck = ~pins.ck;
    task automatic issue(input logic [3:0] c, input logic [2:0] b, input logic [12:0] a);
        @(negedge pins.ck);
        {pins.csN, pins.rasN, pins.casN, pins.weN} = c;
        {pins.ba, pins.addr} = {b, a};
        @(negedge pins.ck);
        // idle cycle; released lines show the inverse
        {pins.csN, pins.ba, pins.addr} = {1'b1, ~b, ~a};
    endtask
    task automatic set_odt(input logic v);
        @(negedge pins.ck);
        pins.odt = v;
    endtask
    // cke moves at falling edges, odt long settled
    task automatic set_cke(input logic v);
        @(negedge pins.ck);
        pins.cke = v;
    endtask
endmodule

// *** ddrac_core_checker.sv ***
module ddrac_core_checker (
    input wire logic                   ref_clk,
    input wire logic                   rst,
    input wire logic                   ckPin,
    input wire logic                   odtPin,
    input wire logic                   beatValid,
    input wire ddrac_pkg::ddrac_beat_t beat,
    input wire logic                   termOn,
    input wire ddrac_pkg::ddrac_rtt_t  rttSel,
    input wire logic [3:0]             readLatency,
    input wire logic [3:0]             writeLatency,
    input wire logic                   powerDown,
    input wire logic                   selfRefresh
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [2:0] ckS, odtS;  // Two sync flops, then previous
    logic [2:0] hist;       // Odt at the last three rises
    logic [2:0] cnt;        // Beat index in burst
    logic [9:3] blk;        // Column block of burst
    wire ckRise = ckS[1] & ~ckS[2];
    wire ckFall = ~ckS[1] & ckS[2];
    wire norm = !powerDown && !selfRefresh && rttSel != ddrac_pkg::RTT_OFF;
    // Mirror the pin sampling
    always_ff @(posedge ref_clk) begin
        ckS <= rst ? 3'h0 : {ckS[1:0], ckPin};
        odtS <= rst ? 3'h0 : {odtS[1:0], odtPin};
        hist <= rst ? 3'h0 : (ckRise ? {hist[1:0], odtS[1]} : hist);
        cnt <= rst ? 3'h0 : (beatValid ? (beat.last ? 3'h0 : cnt + 3'h1) : cnt);
        blk <= (beatValid && cnt == 3'h0) ? beat.col[9:3] : blk;
    end
    default clocking @(posedge ref_clk); endclocking
    default disable iff (rst);
    sequence s_quiet;
        !beatValid [*5];
    endsequence
    a_lat_pair: assert property (readLatency != 4'h0 |-> writeLatency == readLatency - 4'h1)
        else $error("write latency not one less");
    a_lat_rise: assert property ($changed(readLatency) && !$past(rst) && !$past(rst, 2)
        |-> $past(ckRise, 2) || $past(ckRise, 3)) else $error("latency off a CK rise");
    a_rtt_rise: assert property ($changed(rttSel) && !$past(rst)
        |-> $past(ckRise, 2) || $past(ckRise, 3)) else $error("code off a CK rise");
    a_term_on: assert property ($rose(termOn) && norm && $past(norm)
        |-> $past(ckRise) && hist[2]) else $error("bad turn-on");
    a_term_off: assert property ($fell(termOn) && norm && $past(norm)
        |-> $past(ckFall) && !hist[2]) else $error("bad turn-off");
    a_code_off: assert property ((rttSel == ddrac_pkg::RTT_OFF) [*3] |-> !termOn)
        else $error("term on with code off");
    a_beat_gap: assert property (beatValid |=> s_quiet) else $error("beats too close");
    a_last_beat: assert property (beatValid && beat.last |-> cnt == 3'h3 || cnt == 3'h7)
        else $error("bad burst length");
    a_burst_blk: assert property (beatValid && cnt != 3'h0 |-> beat.col[9:3] == blk)
        else $error("burst left its block");
endmodule
bind ddrac_core ddrac_core_checker ddrac_core_checker_inst (.ref_clk, .rst, .ckPin, .odtPin,
    .beatValid, .beat, .termOn, .rttSel, .readLatency, .writeLatency, .powerDown, .selfRefresh);

// *** ddrac_core_tb.sv ***
module ddrac_core_tb;
    timeunit 1ns;
    timeprecision 100ps;
    localparam logic [3:0] ACT = 4'h3, RD = 4'h5, WR = 4'h4, PRE = 4'h2, MRS = 4'h0, REF = 4'h1;
    logic                        ref_clk = 1'b0;
    logic                        rst = 1'b1;
    logic                        beatReady = 1'b1;
    ddrac_pkg::ddrac_pins_t      pins;  // From the controller model
    ddrac_pkg::ddrac_beat_t      beat;
    ddrac_pkg::ddrac_rtt_t       rttSel;
    logic                        beatValid, colReady, termOn, powerDown, selfRefresh;
    logic [ddrac_pkg::LAT_W-1:0] readLatency, writeLatency;
    logic [ddrac_pkg::NBANK-1:0] bankOpen;
    int                          failures = 0;
    int                          checks_done = 0;
    always #5 ref_clk = ~ref_clk;
    ddrac_ctl_model ddrac_ctl_model_inst (.pins(pins));
    ddrac_core ddrac_core_inst (.ref_clk, .rst, .ckPin(pins.ck), .ckePin(pins.cke),
        .odtPin(pins.odt), .csNPin(pins.csN), .rasNPin(pins.rasN), .casNPin(pins.casN),
        .weNPin(pins.weN), .baPin(pins.ba), .addrPin(pins.addr), .beatReady, .beatValid, .beat,
        .colReady, .termOn, .rttSel, .readLatency, .writeLatency, .bankOpen, .powerDown,
        .selfRefresh);
    task automatic cmp(input logic [15:0] got, input logic [15:0] exp, input string what);
        checks_done++;
        if (got !== exp) begin
            failures++;
            $display("BAD %0t %s got %0h exp %0h", $time, what, got, exp);
        end
    endtask
    task automatic end_sim();
        $display("checks %0d failures %0d", checks_done, failures);
        if (failures == 0 && checks_done > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    task automatic cmd(input logic [3:0] c, input logic [2:0] b, input logic [12:0] a);
        ddrac_ctl_model_inst.issue(c, b, a);
    endtask
    // Next beat pulse, bounded
    task automatic get_beat();
        int n;
        n = 0;
        do begin
            @(posedge ref_clk);
            n++;
        end while (beatValid !== 1'b1 && n < 400);
        cmp(16'(n < 400), 16'h1, "beat wait");
    endtask
    // Each termination code with AL 2
    task automatic t_term();
        for (int c = 0; c < 4; c++) begin
            cmd(MRS, 3'h1, {6'h0, c[1], 3'h2, c[0], 2'h0});
            cmp(16'(rttSel), 16'(c), "rtt");
            ddrac_ctl_model_inst.set_odt(1'b1);
            repeat (4) @(posedge pins.ck);
            cmp(16'(termOn), 16'(c != 0), "on");
            ddrac_ctl_model_inst.set_odt(1'b0);
            repeat (4) @(posedge pins.ck);
            cmp(16'(termOn), 16'h0, "off");
        end
        cmp(16'({readLatency, writeLatency}), 16'h54, "al");
    endtask
    // BL8 interleaved read, CL 4
    task automatic t_read8();
        cmd(MRS, 3'h0, 13'h004B);
        cmp(16'({readLatency, writeLatency}), 16'h65, "cl");
        // activate first, a lone BL8 read
        cmd(ACT, 3'h5, 13'h1234);
        cmp(16'(bankOpen), 16'h20, "open");
        cmd(RD, 3'h5, 13'h003D);
        repeat (2) @(posedge pins.ck);
        cmp(16'(beat.col), 16'h0, "early");
        for (int i = 0; i < 8; i++) begin
            get_beat();
            cmp(16'(beat.col), 16'({7'h07, 3'h5 ^ 3'(i)}), "col");
            cmp(16'({beat.write, beat.last, beat.dataDelay}), 16'({1'b0, i == 7, 4'h4}), "rd");
        end
        cmp(16'({beat.bank, beat.row}), 16'({3'h5, 13'h1234}), "row");
    endtask
    // BL4 sequential write, auto-precharge
    task automatic t_write4();
        cmd(PRE, 3'h5, 13'h0000);
        cmp(16'(bankOpen), 16'h0, "pre");
        cmd(MRS, 3'h0, 13'h0042);
        cmd(ACT, 3'h5, 13'h0ABC);
        cmd(WR, 3'h5, 13'h0406);
        for (int i = 0; i < 4; i++) begin
            get_beat();
            cmp(16'(beat.col), 16'({1'b1, 2'(i + 2)}), "col");
            cmp(16'({beat.write, beat.last, beat.dataDelay}), 16'({1'b1, i == 3, 4'h3}), "wr");
        end
        repeat (2) @(posedge pins.ck);
        cmp(16'(bankOpen), 16'h0, "autopre");
    endtask
    // Stall the sink until the queue refuses
    task automatic t_fill();
        @(posedge ref_clk) beatReady <= 1'b0;
        cmd(ACT, 3'h2, 13'h0007);
        repeat (5) cmd(RD, 3'h2, 13'h0000);
        cmp(16'(colReady), 16'h0, "full");
        @(posedge ref_clk) beatReady <= 1'b1;
        repeat (20) get_beat();
        cmp(16'(colReady), 16'h1, "drained");
    endtask
    // Standard power-down keeps fixed delays, self refresh forces off
    task automatic t_power();
        ddrac_ctl_model_inst.set_cke(1'b0);
        repeat (2) @(posedge pins.ck);
        cmp(16'(powerDown), 16'h1, "pd");
        ddrac_ctl_model_inst.set_odt(1'b1);
        repeat (3) @(posedge pins.ck);
        cmp(16'(termOn), 16'h0, "pd early");
        @(posedge pins.ck);
        cmp(16'(termOn), 16'h1, "pd on");
        cmd(REF, 3'h0, 13'h0000);
        cmp(16'({selfRefresh, powerDown, termOn}), 16'h4, "sr");
        ddrac_ctl_model_inst.set_cke(1'b1);
        repeat (8) @(posedge pins.ck);
        cmp(16'({selfRefresh, powerDown, termOn}), 16'h1, "sr exit");
    endtask
    initial begin
        repeat (16) @(posedge ref_clk);
        rst <= 1'b0;
        repeat (4) @(posedge ref_clk);
        cmp(16'({readLatency, writeLatency, termOn, colReady}), 16'h0C9, "reset");
        t_term();
        t_read8();
        t_write4();
        t_fill();
        t_power();
        end_sim();
    end
    // Watchdog, well past the expected run
    initial begin
        #200us;
        failures++;
        end_sim();
    end
endmodule
